/* File: logic/status_enhance_probe_regs.sv */
// status flags, sync period counts, enhancement controls and pixel probe
//
// Behaviour
// - quality-ready flag in status bit 2
// - frequency-calibration-done flag in status bit 1
// - not-full-screen flag in status bit 0
// - 8-bit line period in clock cycles
// - 16-bit frame period in clock cycles
// - text control bit 0 enables text boost
// - text level bits 6..2, range 0..14
// - sharpness control bit 0 enables sharpening
// - sharpness level bits 6..2, range 1..19
// - aux bits 3..0 give text threshold
// - aux bits 6..5 pick frame modulation
// - 11-bit probe column over two registers
// - 11-bit probe row over two registers
// - 24-bit probed pixel over three registers
// - clear bit zero drops not-full-screen flag
`timescale 1ns/1ps
`include "enh_regs_cfg.svh"

module status_enhance_probe_regs
   import enh_regs_pkg::*;
#(
   parameter int LINE_W = 8,
   parameter int FRAME_W = 16
) (
   input logic MCLK,
   input logic RSTN,
   input reg_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   input logic QUALITY_DONE,
   input logic FREQ_DONE,
   input logic NONFULL_DET,
   input logic HSYNC_IN,
   input logic VSYNC_IN,
   input logic [23:0] PROBE_PIXEL,
   output enh_cfg_t ENHANCE,
   output logic [10:0] PROBE_X,
   output logic [10:0] PROBE_Y
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // out-of-range levels are held at the nearest legal one so the
   // filters never see a code they were not built for
   function automatic logic [4:0] clamp_lvl(input logic [4:0] v,
                                            input logic [4:0] lo,
                                            input logic [4:0] hi);
      logic [4:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   function automatic logic [7:0] hi3(input logic [10:0] v);
      return {5'h00, v[10:8]};
   endfunction

   // ----------------------------------------------------------------
   // period meters
   // ----------------------------------------------------------------
   logic [LINE_W-1:0] line_period;
   logic [FRAME_W-1:0] frame_period;
   logic [15:0] frame_wide;

   period_meter #(.W(LINE_W)) u_line (
      .clk(MCLK),
      .rst_n(rst_n),
      .sync_pin(HSYNC_IN),
      .period(line_period)
   );

   period_meter #(.W(FRAME_W)) u_frame (
      .clk(MCLK),
      .rst_n(rst_n),
      .sync_pin(VSYNC_IN),
      .period(frame_period)
   );

   assign frame_wide = 16'(frame_period);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   regs_st_t s_ff;
   regs_st_t nxt_s;
   logic wr_clr;
   logic clr_nfs;
   logic clr_freq;
   logic clr_qual;
   logic [7:0] rd_val;

   always_comb begin
      nxt_s = s_ff;
      wr_clr = REG_REQ.wr && (REG_REQ.addr == `A_CLR);
      clr_nfs = wr_clr && REG_REQ.wdata[`C_NFS];
      clr_freq = wr_clr && REG_REQ.wdata[`C_FREQ];
      clr_qual = wr_clr && REG_REQ.wdata[`C_QUAL];
      rd_val = 8'h00;

      // a detection landing with its clear keeps the flag set
      nxt_s.qual_ff = (s_ff.qual_ff && !clr_qual) || QUALITY_DONE;
      nxt_s.freq_ff = (s_ff.freq_ff && !clr_freq) || FREQ_DONE;
      nxt_s.nfs_ff = (s_ff.nfs_ff && !clr_nfs) || NONFULL_DET;

      if (REG_REQ.wr) begin
         case (REG_REQ.addr)
            `A_TEXT: begin
               nxt_s.text_ff = REG_REQ.wdata & `TEXT_MASK;
            end
            `A_EDGE: begin
               nxt_s.edge_ff = REG_REQ.wdata & `EDGE_MASK;
            end
            `A_AUX: begin
               nxt_s.aux_ff = REG_REQ.wdata & `AUX_MASK;
            end
            `A_PX_HI: begin
               nxt_s.px_ff[10:8] = REG_REQ.wdata[2:0];
            end
            `A_PX_LO: begin
               nxt_s.px_ff[7:0] = REG_REQ.wdata;
            end
            `A_PY_HI: begin
               nxt_s.py_ff[10:8] = REG_REQ.wdata[2:0];
            end
            `A_PY_LO: begin
               nxt_s.py_ff[7:0] = REG_REQ.wdata;
            end
            default: begin
            end
         endcase
      end

      case (REG_REQ.addr)
         `A_CALIB: begin
            rd_val = {5'h00, s_ff.qual_ff, s_ff.freq_ff, s_ff.nfs_ff};
         end
         `A_LINE: begin
            rd_val = 8'(line_period);
         end
         `A_FRM_HI: begin
            rd_val = frame_wide[15:8];
         end
         `A_FRM_LO: begin
            rd_val = s_ff.frm_lo_ff;
         end
         `A_TEXT: begin
            rd_val = s_ff.text_ff;
         end
         `A_EDGE: begin
            rd_val = s_ff.edge_ff;
         end
         `A_AUX: begin
            rd_val = s_ff.aux_ff;
         end
         `A_PX_HI: begin
            rd_val = hi3(s_ff.px_ff);
         end
         `A_PX_LO: begin
            rd_val = s_ff.px_ff[7:0];
         end
         `A_PY_HI: begin
            rd_val = hi3(s_ff.py_ff);
         end
         `A_PY_LO: begin
            rd_val = s_ff.py_ff[7:0];
         end
         `A_PIX_HI: begin
            rd_val = PROBE_PIXEL[23:16];
         end
         `A_PIX_MID: begin
            rd_val = s_ff.pix_lo_ff[15:8];
         end
         `A_PIX_LO: begin
            rd_val = s_ff.pix_lo_ff[7:0];
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase

      if (REG_REQ.rd) begin
         nxt_s.rdata_ff = rd_val;
         // high byte first freezes the rest, so a pair or triple of
         // reads always belongs to one measurement or one pixel
         if (REG_REQ.addr == `A_FRM_HI) begin
            nxt_s.frm_lo_ff = frame_wide[7:0];
         end
         if (REG_REQ.addr == `A_PIX_HI) begin
            nxt_s.pix_lo_ff = PROBE_PIXEL[15:0];
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
         s_ff.text_ff <= `TEXT_RST;
         s_ff.edge_ff <= `EDGE_RST;
         s_ff.aux_ff <= `AUX_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA = s_ff.rdata_ff;
   assign PROBE_X = s_ff.px_ff;
   assign PROBE_Y = s_ff.py_ff;

   always_comb begin
      ENHANCE.text_en = s_ff.text_ff[0];
      ENHANCE.text_level = clamp_lvl(s_ff.text_ff[6:2], `TEXT_LVL_MIN,
                                     `TEXT_LVL_MAX);
      ENHANCE.edge_en = s_ff.edge_ff[0];
      ENHANCE.edge_level = clamp_lvl(s_ff.edge_ff[6:2], `EDGE_LVL_MIN,
                                     `EDGE_LVL_MAX);
      ENHANCE.text_thresh = s_ff.aux_ff[3:0];
      ENHANCE.fm_mode = s_ff.aux_ff[6:5];
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!rst_n);

   a_qual_flag: assert property (
      QUALITY_DONE |=> s_ff.qual_ff)
      else $error("quality flag not set");
   a_freq_flag: assert property (
      FREQ_DONE |=> s_ff.freq_ff)
      else $error("frequency flag not set");
   a_nfs_flag: assert property (
      NONFULL_DET ##1 !clr_nfs |=> s_ff.nfs_ff)
      else $error("not-full-screen flag lost");
   a_nfs_clear: assert property (
      clr_nfs && !NONFULL_DET |=> !s_ff.nfs_ff)
      else $error("not-full-screen flag not cleared");
   a_text_write: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_TEXT |=>
      ENHANCE.text_en == $past(REG_REQ.wdata[0]))
      else $error("text enable not taken");
   a_text_range: assert property (
      ENHANCE.text_level <= `TEXT_LVL_MAX)
      else $error("text level out of range");
   a_edge_range: assert property (
      ENHANCE.edge_level >= `EDGE_LVL_MIN &&
      ENHANCE.edge_level <= `EDGE_LVL_MAX)
      else $error("sharpness level out of range");
   a_aux_fields: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_AUX |=>
      ENHANCE.fm_mode == $past(REG_REQ.wdata[6:5]) &&
      ENHANCE.text_thresh == $past(REG_REQ.wdata[3:0]))
      else $error("aux fields not taken");
   a_probe_x: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_PX_LO |=>
      PROBE_X[7:0] == $past(REG_REQ.wdata))
      else $error("probe column low byte not taken");
   a_probe_y: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_PY_HI |=>
      PROBE_Y[10:8] == $past(REG_REQ.wdata[2:0]))
      else $error("probe row high bits not taken");
   a_reset_vals: assert property (
      $rose(rst_n) |-> s_ff.text_ff == `TEXT_RST &&
      s_ff.edge_ff == `EDGE_RST && s_ff.aux_ff == `AUX_RST)
      else $error("enhancement reset values wrong");
   a_pixel_read: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_PIX_HI ##1
      REG_REQ.rd && REG_REQ.addr == `A_PIX_MID ##1
      REG_REQ.rd && REG_REQ.addr == `A_PIX_LO |=>
      REG_RDATA == $past(PROBE_PIXEL[7:0], 3))
      else $error("probe pixel bytes not paired");
   a_reserved_zero: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_EDGE |=>
      REG_RDATA[7] == 1'b0 && REG_RDATA[1] == 1'b0)
      else $error("reserved bit reads non-zero");
   a_calib_read: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_CALIB |=>
      REG_RDATA[`B_QUAL] == $past(s_ff.qual_ff) &&
      REG_RDATA[`B_FREQ] == $past(s_ff.freq_ff) &&
      REG_RDATA[`B_NFS] == $past(s_ff.nfs_ff))
      else $error("status byte does not match flags");
   a_set_wins: assert property (
      clr_nfs && NONFULL_DET |=> s_ff.nfs_ff)
      else $error("clear beat a new detection");
   a_line_read: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_LINE |=>
      REG_RDATA == 8'($past(line_period)))
      else $error("line period read wrong");
   a_frame_freeze: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_FRM_HI |=>
      s_ff.frm_lo_ff == $past(frame_wide[7:0]))
      else $error("frame low byte not frozen");
   a_edge_write: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_EDGE |=>
      ENHANCE.edge_en == $past(REG_REQ.wdata[0]))
      else $error("sharpness enable not taken");
   a_text_level: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_TEXT &&
      REG_REQ.wdata[6:2] <= `TEXT_LVL_MAX |=>
      ENHANCE.text_level == $past(REG_REQ.wdata[6:2]))
      else $error("legal text level not passed through");
   a_probe_x_hi: assert property (
      REG_REQ.wr && REG_REQ.addr == `A_PX_HI |=>
      PROBE_X[10:8] == $past(REG_REQ.wdata[2:0]))
      else $error("probe column high bits not taken");
   a_clear_reads_zero: assert property (
      REG_REQ.rd && REG_REQ.addr == `A_CLR |=> REG_RDATA == 8'h00)
      else $error("clear register reads non-zero");

   c_nfs_clear: cover property (s_ff.nfs_ff ##1 clr_nfs ##1 !s_ff.nfs_ff);
   c_pix_triple: cover property (
      REG_REQ.rd && REG_REQ.addr == `A_PIX_HI ##1
      REG_REQ.rd && REG_REQ.addr == `A_PIX_MID ##1
      REG_REQ.rd && REG_REQ.addr == `A_PIX_LO);
   c_edge_sharp: cover property (ENHANCE.edge_en &&
      ENHANCE.edge_level == `EDGE_LVL_MAX);
   c_set_wins: cover property (clr_nfs && NONFULL_DET);

endmodule

/* File: logic/enh_regs_cfg.svh */
// register offsets, field positions, masks and reset values
`ifndef ENH_REGS_CFG_SVH
`define ENH_REGS_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define A_CALIB 8'h4e
`define A_LINE 8'h4f
`define A_FRM_HI 8'h50
`define A_FRM_LO 8'h51
`define A_TEXT 8'h52
`define A_EDGE 8'h53
`define A_AUX 8'h54
`define A_PX_HI 8'h55
`define A_PX_LO 8'h56
`define A_PY_HI 8'h57
`define A_PY_LO 8'h58
`define A_PIX_HI 8'h59
`define A_PIX_MID 8'h5a
`define A_PIX_LO 8'h5b
`define A_CLR 8'h66

// ----------------------------------------------------------------
// status and clear bit positions
// ----------------------------------------------------------------
`define B_QUAL 2
`define B_FREQ 1
`define B_NFS 0
`define C_QUAL 2
`define C_FREQ 1
`define C_NFS 0

// ----------------------------------------------------------------
// writable-bit masks and reset values
// ----------------------------------------------------------------
`define TEXT_MASK 8'h7d
`define EDGE_MASK 8'h7d
`define AUX_MASK 8'h6f
`define TEXT_RST 8'h00
`define EDGE_RST 8'h14
`define AUX_RST 8'h05

// ----------------------------------------------------------------
// level limits
// ----------------------------------------------------------------
`define TEXT_LVL_MIN 5'h00
`define TEXT_LVL_MAX 5'h0e
`define EDGE_LVL_MIN 5'h01
`define EDGE_LVL_MAX 5'h13

`endif

/* File: logic/enh_regs_pkg.sv */
// types shared by the status, enhancement and probe register slice
package enh_regs_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic text_en;
      logic [4:0] text_level;
      logic edge_en;
      logic [4:0] edge_level;
      logic [3:0] text_thresh;
      logic [1:0] fm_mode;
   } enh_cfg_t;

   typedef struct packed {
      logic [7:0] text_ff;
      logic [7:0] edge_ff;
      logic [7:0] aux_ff;
      logic [10:0] px_ff;
      logic [10:0] py_ff;
      logic qual_ff;
      logic freq_ff;
      logic nfs_ff;
      logic [7:0] frm_lo_ff;
      logic [15:0] pix_lo_ff;
      logic [7:0] rdata_ff;
   } regs_st_t;

   typedef struct packed {
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic level_ff;
      logic seen_ff;
      logic [15:0] cnt_ff;
      logic [15:0] result_ff;
   } period_st_t;

endpackage

/* File: logic/period_meter.sv */
// counts clock cycles between rising edges of a sync pin
`timescale 1ns/1ps
`include "enh_regs_cfg.svh"

module period_meter
   import enh_regs_pkg::*;
#(
   parameter int W = 8
) (
   input logic clk,
   input logic rst_n,
   input logic sync_pin,
   output logic [W-1:0] period
);

   // counter saturates rather than wrapping on very long periods
   localparam logic [15:0] MAXC = 16'((33'h1 << W) - 33'h1);

   period_st_t s_ff;
   period_st_t nxt_s;
   logic rise;

   // ----------------------------------------------------------------
   // pin filter and counter
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.s1_ff = sync_pin;
      nxt_s.s2_ff = s_ff.s1_ff;
      nxt_s.s3_ff = s_ff.s2_ff;
      rise = (s_ff.s2_ff == s_ff.s3_ff) && s_ff.s2_ff && !s_ff.level_ff;
      if (s_ff.s2_ff == s_ff.s3_ff) begin
         nxt_s.level_ff = s_ff.s2_ff;
      end
      if (rise) begin
         nxt_s.cnt_ff = 16'h0001;
         nxt_s.seen_ff = 1'b1;
         // first edge only starts timing: no partial period shown
         if (s_ff.seen_ff) begin
            nxt_s.result_ff = s_ff.cnt_ff;
         end
      end else if (s_ff.cnt_ff != MAXC) begin
         nxt_s.cnt_ff = s_ff.cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign period = s_ff.result_ff[W-1:0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_period_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !rise |=> $stable(s_ff.result_ff))
      else $error("period changed without a sync edge");
   a_period_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      rise && s_ff.seen_ff |=> s_ff.result_ff == $past(s_ff.cnt_ff))
      else $error("period not taken from count");

endmodule

/* File: tb/status_enhance_probe_regs_tb_top.sv */
// self-checking bench for the status, enhancement and probe registers
`timescale 1ns/1ps
`include "enh_regs_cfg.svh"

module status_enhance_probe_regs_tb_top
   import enh_regs_pkg::*;
;
   logic mclk;
   logic rstn;
   reg_req_t reg_req;
   logic [7:0] reg_rdata;
   logic quality_done;
   logic freq_done;
   logic nonfull_det;
   logic hsync_in;
   logic vsync_in;
   logic [23:0] probe_pixel;
   enh_cfg_t enhance;
   logic [10:0] probe_x;
   logic [10:0] probe_y;
   logic [7:0] rd;
   int errors;
   int samples_checked;
   int cycles;

   status_enhance_probe_regs i_dut (
      .MCLK(mclk),
      .RSTN(rstn),
      .REG_REQ(reg_req),
      .REG_RDATA(reg_rdata),
      .QUALITY_DONE(quality_done),
      .FREQ_DONE(freq_done),
      .NONFULL_DET(nonfull_det),
      .HSYNC_IN(hsync_in),
      .VSYNC_IN(vsync_in),
      .PROBE_PIXEL(probe_pixel),
      .ENHANCE(enhance),
      .PROBE_X(probe_x),
      .PROBE_Y(probe_y)
   );

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // whole run needs about 5000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         $display("timeout after %0d cycles", cycles);
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h, expected %h",
                  $time, seen, exp);
      end
   endtask

   // request held one cycle, released at the edge that takes it
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk);
      reg_req <= '0;
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge mclk);
      reg_req <= '0;
      #1;
      rd = reg_rdata;
   endtask

   task automatic boost_case(input logic [7:0] a, input logic [7:0] w,
                             input logic [7:0] r, input logic en,
                             input logic [4:0] lv);
      wr_reg(a, w);
      if (a == `A_TEXT) begin
         check(enhance.text_en, en);
         check(enhance.text_level, lv);
      end else begin
         check(enhance.edge_en, en);
         check(enhance.edge_level, lv);
      end
      rd_reg(a);
      check(rd, r);
   endtask

   task automatic aux_case(input logic [7:0] w, input logic [7:0] r,
                           input logic [3:0] th, input logic [1:0] fm);
      wr_reg(`A_AUX, w);
      check(enhance.text_thresh, th);
      check(enhance.fm_mode, fm);
      rd_reg(`A_AUX);
      check(rd, r);
   endtask

   task automatic flag_pulse(input int b);
      @(posedge mclk);
      if (b == 0) nonfull_det <= 1'b1;
      if (b == 1) freq_done <= 1'b1;
      if (b == 2) quality_done <= 1'b1;
      @(posedge mclk);
      nonfull_det <= 1'b0;
      freq_done <= 1'b0;
      quality_done <= 1'b0;
      rd_reg(`A_CALIB);
   endtask

   // detection and clear on one edge: the detection must win
   task automatic clr_race();
      @(posedge mclk);
      nonfull_det <= 1'b1;
      reg_req <= '{addr: `A_CLR, wr: 1'b1, rd: 1'b0, wdata: 8'h01};
      @(posedge mclk);
      nonfull_det <= 1'b0;
      reg_req <= '0;
      rd_reg(`A_CALIB);
   endtask

   // back-to-back pixel reads; pixel moves once the high byte is taken
   task automatic pix_triple(input logic [23:0] px);
      @(posedge mclk);
      probe_pixel <= px;
      reg_req <= '{addr: `A_PIX_HI, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge mclk);
      probe_pixel <= ~px;
      reg_req.addr <= `A_PIX_MID;
      #1;
      check(reg_rdata, px[23:16]);
      @(posedge mclk);
      reg_req.addr <= `A_PIX_LO;
      #1;
      check(reg_rdata, px[15:8]);
      @(posedge mclk);
      reg_req <= '0;
      #1;
      check(reg_rdata, px[7:0]);
   endtask

   // rising edges exactly per cycles apart, pin high for 4 cycles after each edge
   task automatic sync_run(input logic v, input int per, input int n);
      repeat (n) begin
         @(posedge mclk);
         if (v) vsync_in <= 1'b1; else hsync_in <= 1'b1;
         repeat (4) @(posedge mclk);
         if (v) vsync_in <= 1'b0; else hsync_in <= 1'b0;
         repeat (per - 5) @(posedge mclk);
      end
      repeat (8) @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults();
      check(enhance.text_en, 1'b0);
      check(enhance.edge_level, 5'h05);
      check(enhance.text_thresh, 4'h5);
      rd_reg(`A_TEXT);
      check(rd, 8'h00);
      rd_reg(`A_EDGE);
      check(rd, 8'h14);
      rd_reg(`A_AUX);
      check(rd, 8'h05);
      $display("test defaults done");
   endtask

   task automatic t_boost();
      boost_case(`A_TEXT, 8'h09, 8'h09, 1'b1, 5'h02);
      boost_case(`A_TEXT, 8'h38, 8'h38, 1'b0, 5'h0e);
      boost_case(`A_TEXT, 8'hff, 8'h7d, 1'b1, 5'h0e);
      boost_case(`A_EDGE, 8'h05, 8'h05, 1'b1, 5'h01);
      boost_case(`A_EDGE, 8'h4c, 8'h4c, 1'b0, 5'h13);
      boost_case(`A_EDGE, 8'h82, 8'h00, 1'b0, 5'h01);
      aux_case(8'hff, 8'h6f, 4'hf, 2'h3);
      aux_case(8'h20, 8'h20, 4'h0, 2'h1);
      aux_case(8'h4a, 8'h4a, 4'ha, 2'h2);
      aux_case(8'h90, 8'h00, 4'h0, 2'h0);
      $display("test enhancement controls done");
   endtask

   task automatic t_probe();
      wr_reg(`A_PX_HI, 8'h05);
      wr_reg(`A_PX_LO, 8'ha3);
      wr_reg(`A_PY_HI, 8'h02);
      wr_reg(`A_PY_LO, 8'h3c);
      check(probe_x, 11'h5a3);
      check(probe_y, 11'h23c);
      rd_reg(`A_PY_HI);
      check(rd, 8'h02);
      @(posedge mclk);
      probe_pixel <= 24'h123456;
      rd_reg(`A_PIX_HI);
      check(rd, 8'h12);
      // later bytes come from the copy frozen by the high-byte read
      @(posedge mclk);
      probe_pixel <= 24'habcdef;
      rd_reg(`A_PIX_MID);
      check(rd, 8'h34);
      rd_reg(`A_PIX_LO);
      check(rd, 8'h56);
      pix_triple(24'h9a7b5c);
      $display("test probe done");
   endtask

   task automatic t_status();
      wr_reg(`A_CALIB, 8'hff);
      rd_reg(`A_CALIB);
      check(rd, 8'h00);
      flag_pulse(0);
      check(rd, 8'h01);
      flag_pulse(1);
      check(rd, 8'h03);
      flag_pulse(2);
      check(rd, 8'h07);
      wr_reg(`A_CLR, 8'h01);
      rd_reg(`A_CALIB);
      check(rd, 8'h06);
      clr_race();
      check(rd, 8'h07);
      wr_reg(`A_CLR, 8'h07);
      rd_reg(`A_CALIB);
      check(rd, 8'h00);
      rd_reg(`A_CLR);
      check(rd, 8'h00);
      rd_reg(8'h70);
      check(rd, 8'h00);
      $display("test status flags done");
   endtask

   task automatic t_period();
      sync_run(1'b0, 40, 3);
      rd_reg(`A_LINE);
      check(rd, 8'd40);
      repeat (500) @(posedge mclk);
      rd_reg(`A_LINE);
      check(rd, 8'd40);
      sync_run(1'b0, 300, 3);
      rd_reg(`A_LINE);
      check(rd, 8'hff);
      sync_run(1'b1, 1000, 3);
      rd_reg(`A_FRM_HI);
      check(rd, 8'h03);
      rd_reg(`A_FRM_LO);
      check(rd, 8'he8);
      $display("test sync periods done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      reg_req = '0;
      quality_done = 1'b0;
      freq_done = 1'b0;
      nonfull_det = 1'b0;
      hsync_in = 1'b0;
      vsync_in = 1'b0;
      probe_pixel = 24'h000000;
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      // internal reset lifts two edges after release
      repeat (3) @(posedge mclk);
      #1;
      t_defaults();
      t_boost();
      t_probe();
      t_status();
      t_period();
      end_of_test();
   end
endmodule
